// ---- safety_cmd_code_map.sv ----
// Purpose: maps a command code to a target and an access verdict
// Assumes: request signals come from logic on the same clock
// Notes: purely combinational, no state
`include "safety_cmd_params.svh"

module safety_cmd_code_map (
	// decode carrier
	safety_cmd_decode_if.map dec
);

	// ************************************************************
	// write code table
	// ************************************************************
	always_comb begin
		dec.wr_idx = `IDX_STATUS_TWO;
		dec.access = safety_cmd_pkg::ACC_NONE;
		case (dec.code)
			`CODE_WRITE_WATCHDOG_FAIL_COUNTER: begin
				dec.wr_idx = `IDX_STATUS_TWO;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_HOST_ERROR_FAIL_COUNTER: begin
				dec.wr_idx = `IDX_STATUS_THREE;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_DEVICE_ERROR_COUNTER: begin
				dec.wr_idx = `IDX_STATUS_FOUR;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_PWM_HIGH_TIME_MAX: begin
				dec.wr_idx = `IDX_PWM_HIGH_MAX;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_PWM_HIGH_TIME_MIN: begin
				dec.wr_idx = `IDX_PWM_HIGH_MIN;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_PWM_LOW_TIME_MAX: begin
				dec.wr_idx = `IDX_PWM_LOW_MAX;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_PWM_LOW_TIME_MIN: begin
				dec.wr_idx = `IDX_PWM_LOW_MIN;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_POWER_DOWN_THRESHOLD: begin
				dec.wr_idx = `IDX_POWER_DOWN;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_CONFIG_CRC_REFERENCE: begin
				dec.wr_idx = `IDX_CRC_REFERENCE;
				dec.access = safety_cmd_pkg::ACC_GUARDED;
			end
			`CODE_WRITE_ANALOG_SELFTEST_CONTROL: begin
				dec.wr_idx = `IDX_ANALOG_SELFTEST;
				dec.access = safety_cmd_pkg::ACC_FREE;
			end
			`CODE_WRITE_LOGIC_SELFTEST_CONTROL: begin
				dec.wr_idx = `IDX_LOGIC_SELFTEST;
				dec.access = safety_cmd_pkg::ACC_FREE;
			end
			`CODE_WRITE_SAFETY_CHECK_CONTROL: begin
				dec.wr_idx = `IDX_SAFETY_CHECK;
				dec.access = safety_cmd_pkg::ACC_FREE;
			end
			default: begin
				dec.access = safety_cmd_pkg::ACC_NONE;
			end
		endcase
	end

	// ************************************************************
	// read code table
	// ************************************************************
	always_comb begin
		dec.rd_hit = dec.valid;
		dec.rd_idx = `IDX_STATUS_TWO;
		case (dec.code)
			`CODE_READ_STATUS_TWO: dec.rd_idx = `IDX_STATUS_TWO;
			`CODE_READ_STATUS_THREE: dec.rd_idx = `IDX_STATUS_THREE;
			`CODE_READ_STATUS_FOUR: dec.rd_idx = `IDX_STATUS_FOUR;
			`CODE_READ_PWM_HIGH_TIME_MAX: dec.rd_idx = `IDX_PWM_HIGH_MAX;
			`CODE_READ_PWM_HIGH_TIME_MIN: dec.rd_idx = `IDX_PWM_HIGH_MIN;
			`CODE_READ_PWM_LOW_TIME_MAX: dec.rd_idx = `IDX_PWM_LOW_MAX;
			`CODE_READ_PWM_LOW_TIME_MIN: dec.rd_idx = `IDX_PWM_LOW_MIN;
			`CODE_READ_POWER_DOWN_THRESHOLD: dec.rd_idx = `IDX_POWER_DOWN;
			`CODE_READ_ANALOG_SELFTEST_CONTROL: dec.rd_idx = `IDX_ANALOG_SELFTEST;
			`CODE_READ_LOGIC_SELFTEST_CONTROL: dec.rd_idx = `IDX_LOGIC_SELFTEST;
			`CODE_READ_SAFETY_CHECK_CONTROL: dec.rd_idx = `IDX_SAFETY_CHECK;
			default: dec.rd_hit = 1'b0;
		endcase
	end

	// ************************************************************
	// access verdict
	// ************************************************************
	// guarded writes need both the state_a state and a clear lock
	assign dec.wr_en = dec.valid && ((dec.access == safety_cmd_pkg::ACC_FREE) ||
		((dec.access == safety_cmd_pkg::ACC_GUARDED) && dec.diag && !dec.locked));
	assign dec.ignored = dec.valid && (dec.access == safety_cmd_pkg::ACC_GUARDED) &&
		!(dec.diag && !dec.locked);
	assign dec.nibble_only = (dec.wr_idx <= `IDX_LAST_COUNTER);

endmodule : safety_cmd_code_map

// ---- safety_cmd_decode_if.sv ----
// Purpose: carrier between the code map and the core
// Assumes: one clock, all signals combinational
// Notes: map drives the verdict, core drives the request
`include "safety_cmd_params.svh"

interface safety_cmd_decode_if;
	logic [`CODE_W-1:0] code;
	logic valid;
	logic diag;
	logic locked;
	logic wr_en;
	logic [`IDX_W-1:0] wr_idx;
	logic nibble_only;
	logic rd_hit;
	logic [`IDX_W-1:0] rd_idx;
	logic ignored;
	safety_cmd_pkg::access_t access;

	modport map (input code, valid, diag, locked,
		output wr_en, wr_idx, nibble_only, rd_hit, rd_idx, ignored, access);
	modport core (output code, valid, diag, locked,
		input wr_en, wr_idx, nibble_only, rd_hit, rd_idx, ignored, access);
endinterface : safety_cmd_decode_if

// ---- safety_cmd_params.svh ----
// Purpose: named constants of the safety command decoder
// Assumes: 8-bit command codes and 8-bit data words
// Notes: definitions only
`ifndef SAFETY_CMD_PARAMS_SVH
`define SAFETY_CMD_PARAMS_SVH

// ************************************************************
// widths and counts
// ************************************************************
`define CODE_W 8
`define DATA_W 8
`define IDX_W 4
`define NUM_TGT 11
`define NUM_CNT 3
`define COUNT_W 4
`define COUNT_HI 3
`define COUNT_LO 0
`define FLAG_HI 7
`define FLAG_LO 4
`define COUNT_ONE 4'h1
`define COUNT_MAX 4'hf

// ************************************************************
// write command codes
// ************************************************************
`define CODE_WRITE_WATCHDOG_FAIL_COUNTER 8'ha4
`define CODE_WRITE_HOST_ERROR_FAIL_COUNTER 8'ha7
`define CODE_WRITE_DEVICE_ERROR_COUNTER 8'ha8
`define CODE_WRITE_PWM_HIGH_TIME_MAX 8'h91
`define CODE_WRITE_PWM_HIGH_TIME_MIN 8'h92
`define CODE_WRITE_PWM_LOW_TIME_MAX 8'h94
`define CODE_WRITE_PWM_LOW_TIME_MIN 8'h97
`define CODE_WRITE_POWER_DOWN_THRESHOLD 8'h98
`define CODE_WRITE_CONFIG_CRC_REFERENCE 8'h9b
`define CODE_WRITE_ANALOG_SELFTEST_CONTROL 8'hab
`define CODE_WRITE_LOGIC_SELFTEST_CONTROL 8'had
`define CODE_WRITE_SAFETY_CHECK_CONTROL 8'hae

// ************************************************************
// read command codes
// ************************************************************
`define CODE_READ_STATUS_TWO 8'h52
`define CODE_READ_STATUS_THREE 8'h54
`define CODE_READ_STATUS_FOUR 8'h57
`define CODE_READ_PWM_HIGH_TIME_MAX 8'h61
`define CODE_READ_PWM_HIGH_TIME_MIN 8'h62
`define CODE_READ_PWM_LOW_TIME_MAX 8'h64
`define CODE_READ_PWM_LOW_TIME_MIN 8'h67
`define CODE_READ_POWER_DOWN_THRESHOLD 8'h68
`define CODE_READ_ANALOG_SELFTEST_CONTROL 8'h5b
`define CODE_READ_LOGIC_SELFTEST_CONTROL 8'h5d
`define CODE_READ_SAFETY_CHECK_CONTROL 8'h5e

// ************************************************************
// storage indices, counters first
// ************************************************************
`define IDX_STATUS_TWO 4'h0
`define IDX_STATUS_THREE 4'h1
`define IDX_STATUS_FOUR 4'h2
`define IDX_PWM_HIGH_MAX 4'h3
`define IDX_PWM_HIGH_MIN 4'h4
`define IDX_PWM_LOW_MAX 4'h5
`define IDX_PWM_LOW_MIN 4'h6
`define IDX_POWER_DOWN 4'h7
`define IDX_CRC_REFERENCE 4'h8
`define IDX_ANALOG_SELFTEST 4'h9
`define IDX_LOGIC_SELFTEST 4'ha
`define IDX_SAFETY_CHECK 4'hb
`define IDX_LAST_COUNTER 4'h2

`endif

// ---- safety_cmd_pkg.sv ----
// Purpose: shared types of the safety command decoder
// Assumes: constants come from the params header
// Notes: nothing here is imported, users write the scope
`include "safety_cmd_params.svh"

package safety_cmd_pkg;

	// ************************************************************
	// access classes of a command code
	// ************************************************************
	typedef enum logic [2:0] {
		ACC_NONE = 3'h1,
		ACC_GUARDED = 3'h2,
		ACC_FREE = 3'h4
	} access_t;

	// ************************************************************
	// complete state of the core
	// ************************************************************
	typedef struct packed {
		logic [`NUM_TGT:0][`DATA_W-1:0] regs;
		logic [`DATA_W-1:0] rd_data;
		logic rd_valid;
		logic ignored;
	} core_state_t;

endpackage : safety_cmd_pkg

// ---- safety_host_model.sv ----
// Purpose: host controller model that issues decoder commands
// Assumes: one command per call except write_then_read, which issues two, launched just after a rising edge
// Notes: the bench picks state and lock itself to provoke refusals on purpose
`include "safety_cmd_params.svh"

module safety_host_model (
	// clock
	input wire logic mclk_in,
	// command and device state drive
	output logic cmd_valid_out,
	output logic [`CODE_W-1:0] cmd_code_out,
	output logic [`DATA_W-1:0] cmd_data_out,
	output logic state_a_out,
	output logic config_lock_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// idle levels and command tasks
	// ************************************************************
	// quiet bus at time zero, locked and out of state_a state like a fresh device
	initial begin
		cmd_valid_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_data_out = 8'h00;
		state_a_out = 1'b0;
		config_lock_out = 1'b1;
	end

	// one command word; state and lock are levels and stay as left
	task automatic issue(input logic [7:0] code, input logic [7:0] data, input logic diag, input logic lock);
		@(posedge mclk_in);
		cmd_valid_out <= 1'b1;
		cmd_code_out <= code;
		cmd_data_out <= data;
		state_a_out <= diag;
		config_lock_out <= lock;
		@(posedge mclk_in);
		cmd_valid_out <= 1'b0;
		// scramble the data lines once the word is taken, so stale data never helps
		cmd_data_out <= ~data;
	endtask : issue

	// a proper host enters state_a state and unlocks in the same cycle as a guarded write
	task automatic guarded_write(input logic [7:0] code, input logic [7:0] data);
		issue(code, data, 1'b1, 1'b0);
	endtask : guarded_write

	// guarded write, then a read word in the very next cycle with no idle gap
	task automatic write_then_read(input logic [7:0] wcode, input logic [7:0] data, input logic [7:0] rcode);
		@(posedge mclk_in);
		cmd_valid_out <= 1'b1;
		cmd_code_out <= wcode;
		cmd_data_out <= data;
		state_a_out <= 1'b1;
		config_lock_out <= 1'b0;
		@(posedge mclk_in);
		cmd_code_out <= rcode;
		@(posedge mclk_in);
		cmd_valid_out <= 1'b0;
		cmd_data_out <= ~data;
	endtask : write_then_read
endmodule : safety_host_model

// ---- safety_spi_command_decoder.sv ----
// Purpose: executes decoded safety commands on the config and counter storage
// Assumes: command words arrive framed and on mclk_in, one per cycle with cmd_valid_in high
// Notes: status upper nibbles follow hardware flags, software owns only counters
`include "safety_cmd_params.svh"

// Functional notes
// - watchdog counter write only in state_a state, touching status two bits 3:0.
// - host error counter write only in state_a state, touching status three bits 3:0.
// - device error counter write only in state_a state, touching status four bits 3:0.
// - all three counter writes are blocked while the configuration lock is set.
// - high-time max threshold: write 0x91 guarded, read 0x61.
// - high-time min threshold: write 0x92 guarded, read 0x62.
// - low-time max threshold: write 0x94 guarded, read 0x64.
// - low-time min threshold: write 0x97 guarded, read 0x67.
// - power-down threshold: write 0x98 guarded, read 0x68.
// - config CRC reference write 0x9B, guarded by lock and state_a state.
// - self-test and safety check control writes 0xAB 0xAD 0xAE ignore the lock.
module safety_spi_command_decoder (
	// clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// command stream from the frame logic
	input wire logic cmd_valid_in,
	input wire logic [`CODE_W-1:0] cmd_code_in,
	input wire logic [`DATA_W-1:0] cmd_data_in,
	// device state from the surrounding controller
	input wire logic state_a_in,
	input wire logic config_lock_in,
	// hardware counter events and status flags
	input wire logic [`NUM_CNT-1:0] count_event_in,
	input wire logic [`NUM_CNT-1:0][`COUNT_W-1:0] status_flags_in,
	// read answer and reject pulse
	output logic rd_valid_out,
	output logic [`DATA_W-1:0] rd_data_out,
	output logic cmd_ignored_out,
	// status registers
	output logic [`DATA_W-1:0] safety_error_status_two_out,
	output logic [`DATA_W-1:0] safety_error_status_three_out,
	output logic [`DATA_W-1:0] safety_error_status_four_out,
	// configuration registers
	output logic [`DATA_W-1:0] pwm_high_time_max_out,
	output logic [`DATA_W-1:0] pwm_high_time_min_out,
	output logic [`DATA_W-1:0] pwm_low_time_max_out,
	output logic [`DATA_W-1:0] pwm_low_time_min_out,
	output logic [`DATA_W-1:0] power_down_threshold_out,
	output logic [`DATA_W-1:0] config_crc_reference_out,
	// control registers
	output logic [`DATA_W-1:0] analog_selftest_control_out,
	output logic [`DATA_W-1:0] logic_selftest_control_out,
	output logic [`DATA_W-1:0] safety_check_control_out
);

	// ************************************************************
	// decode
	// ************************************************************
	safety_cmd_pkg::core_state_t state_q;
	safety_cmd_pkg::core_state_t state_d;
	safety_cmd_decode_if dec ();

	// request side of the carrier, same clock so no synchroniser
	assign dec.code = cmd_code_in;
	assign dec.valid = cmd_valid_in;
	assign dec.diag = state_a_in;
	assign dec.locked = config_lock_in;

	safety_cmd_code_map u_map (
		.dec(dec.map)
	);

	// ************************************************************
	// next state
	// ************************************************************
	// a software write beats a same-cycle increment so the host sees its own value
	always_comb begin
		state_d = state_q;
		state_d.rd_valid = 1'b0;
		state_d.ignored = dec.ignored;
		for (int i = 0; i < `NUM_CNT; i++) begin
			state_d.regs[i][`FLAG_HI:`FLAG_LO] = status_flags_in[i];
			// saturate rather than wrap, a wrapped count would hide failures
			if (count_event_in[i] && (state_q.regs[i][`COUNT_HI:`COUNT_LO] != `COUNT_MAX)) begin
				state_d.regs[i][`COUNT_HI:`COUNT_LO] = `COUNT_W'(state_q.regs[i][`COUNT_HI:`COUNT_LO] + `COUNT_ONE);
			end
		end
		if (dec.wr_en) begin
			if (dec.nibble_only) begin
				state_d.regs[dec.wr_idx][`COUNT_HI:`COUNT_LO] = cmd_data_in[`COUNT_HI:`COUNT_LO];
			end else begin
				state_d.regs[dec.wr_idx] = cmd_data_in;
			end
		end
		if (dec.rd_hit) begin
			state_d.rd_data = state_q.regs[dec.rd_idx];
			state_d.rd_valid = 1'b1;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	// all storage clears to zero on reset
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign rd_valid_out = state_q.rd_valid;
	assign rd_data_out = state_q.rd_data;
	assign cmd_ignored_out = state_q.ignored;
	assign safety_error_status_two_out = state_q.regs[`IDX_STATUS_TWO];
	assign safety_error_status_three_out = state_q.regs[`IDX_STATUS_THREE];
	assign safety_error_status_four_out = state_q.regs[`IDX_STATUS_FOUR];
	assign pwm_high_time_max_out = state_q.regs[`IDX_PWM_HIGH_MAX];
	assign pwm_high_time_min_out = state_q.regs[`IDX_PWM_HIGH_MIN];
	assign pwm_low_time_max_out = state_q.regs[`IDX_PWM_LOW_MAX];
	assign pwm_low_time_min_out = state_q.regs[`IDX_PWM_LOW_MIN];
	assign power_down_threshold_out = state_q.regs[`IDX_POWER_DOWN];
	assign config_crc_reference_out = state_q.regs[`IDX_CRC_REFERENCE];
	assign analog_selftest_control_out = state_q.regs[`IDX_ANALOG_SELFTEST];
	assign logic_selftest_control_out = state_q.regs[`IDX_LOGIC_SELFTEST];
	assign safety_check_control_out = state_q.regs[`IDX_SAFETY_CHECK];

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	logic guard_open;
	assign guard_open = state_a_in && !config_lock_in;

	a_wd_count_write: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_WATCHDOG_FAIL_COUNTER && guard_open
		|=> safety_error_status_two_out[`COUNT_HI:`COUNT_LO] == $past(cmd_data_in[`COUNT_HI:`COUNT_LO])
		&& safety_error_status_two_out[`FLAG_HI:`FLAG_LO] == $past(status_flags_in[0]))
		else $error("watchdog count write did not land in its field only");
	a_host_count_write: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_HOST_ERROR_FAIL_COUNTER && guard_open
		|=> safety_error_status_three_out[`COUNT_HI:`COUNT_LO] == $past(cmd_data_in[`COUNT_HI:`COUNT_LO]))
		else $error("host error count write lost");
	a_dev_count_diag: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_DEVICE_ERROR_COUNTER && !state_a_in && !count_event_in[2]
		|=> $stable(safety_error_status_four_out[`COUNT_HI:`COUNT_LO]))
		else $error("device error count changed outside state_a state");
	a_count_lock_holds: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_HOST_ERROR_FAIL_COUNTER && config_lock_in && !count_event_in[1]
		|=> $stable(safety_error_status_three_out[`COUNT_HI:`COUNT_LO]))
		else $error("locked counter write took effect");
	a_hmax_write_read: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_PWM_HIGH_TIME_MAX && guard_open
		##1 cmd_valid_in && cmd_code_in == `CODE_READ_PWM_HIGH_TIME_MAX
		|=> rd_valid_out && rd_data_out == $past(cmd_data_in, 2))
		else $error("high-time max write then read mismatch");
	a_hmin_guarded: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_PWM_HIGH_TIME_MIN && !guard_open
		|=> $stable(pwm_high_time_min_out) && cmd_ignored_out)
		else $error("guarded high-time min write not refused");
	a_lmax_read: assert property (
		cmd_valid_in && cmd_code_in == `CODE_READ_PWM_LOW_TIME_MAX
		|=> rd_valid_out && rd_data_out == $past(pwm_low_time_max_out))
		else $error("low-time max read wrong");
	a_lmin_write: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_PWM_LOW_TIME_MIN && guard_open
		|=> pwm_low_time_min_out == $past(cmd_data_in) && !cmd_ignored_out)
		else $error("low-time min write lost");
	a_pwd_locked: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_POWER_DOWN_THRESHOLD && config_lock_in
		|=> $stable(power_down_threshold_out))
		else $error("power-down threshold written under lock");
	a_crc_write: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_CONFIG_CRC_REFERENCE
		|=> config_crc_reference_out == ($past(guard_open) ? $past(cmd_data_in) : $past(config_crc_reference_out)))
		else $error("crc reference guard wrong");
	a_selftest_free: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_LOGIC_SELFTEST_CONTROL
		|=> logic_selftest_control_out == $past(cmd_data_in) && !cmd_ignored_out)
		else $error("logic self-test write not taken");
	a_ignore_one_cycle: assert property (
		cmd_ignored_out && !cmd_valid_in |=> !cmd_ignored_out)
		else $error("reject pulse stretched");

	// ************************************************************
	// counters, flag nibbles, free controls, read answers and low-time max guard
	// ************************************************************
	// a full counter must not wrap, a wrap would hide a burst of failures
	a_count_saturates: assert property (
		count_event_in[0] && !cmd_valid_in && safety_error_status_two_out[`COUNT_HI:`COUNT_LO] == `COUNT_MAX
		|=> safety_error_status_two_out[`COUNT_HI:`COUNT_LO] == `COUNT_MAX)
		else $error("watchdog count wrapped past its ceiling");
	// counter writes keep the hardware flag nibble live
	a_flags_untouched: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_DEVICE_ERROR_COUNTER
		|=> safety_error_status_four_out[`FLAG_HI:`FLAG_LO] == $past(status_flags_in[2]))
		else $error("device error write reached the flag nibble");
	// free controls land whatever the lock and the device state
	a_analog_free: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_ANALOG_SELFTEST_CONTROL
		|=> analog_selftest_control_out == $past(cmd_data_in) && !cmd_ignored_out)
		else $error("analog self-test write not taken");
	a_check_free: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_SAFETY_CHECK_CONTROL
		|=> safety_check_control_out == $past(cmd_data_in) && !cmd_ignored_out)
		else $error("safety check control write not taken");
	// a read answer only ever follows a command word
	a_read_needs_cmd: assert property (
		!cmd_valid_in |=> !rd_valid_out)
		else $error("read answer without a command");
	a_lmax_guarded: assert property (
		cmd_valid_in && cmd_code_in == `CODE_WRITE_PWM_LOW_TIME_MAX && !guard_open
		|=> $stable(pwm_low_time_max_out) && cmd_ignored_out)
		else $error("guarded low-time max write not refused");

	c_guarded_accept: cover property (cmd_valid_in && dec.access == safety_cmd_pkg::ACC_GUARDED && guard_open);
	c_guarded_reject: cover property (cmd_ignored_out);
	c_read_answer: cover property (rd_valid_out);
	c_free_under_lock: cover property (cmd_valid_in && dec.access == safety_cmd_pkg::ACC_FREE && config_lock_in);

endmodule : safety_spi_command_decoder

// ---- safety_spi_command_decoder_tb_top.sv ----
// Purpose: self-checking bench of the safety command decoder
// Assumes: host model drives commands, bench drives reset, events and flags
// Notes: expectations come from a reference copy of every register
`include "safety_cmd_params.svh"

module safety_spi_command_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk;
	logic sys_rst;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic [7:0] cmd_data;
	logic state_a;
	logic config_lock;
	logic [2:0] count_event;
	logic [2:0][3:0] status_flags;
	logic rd_valid;
	logic [7:0] rd_data;
	logic ignored;
	logic [7:0] outs [12];
	logic [7:0] expv [12];
	logic [7:0] lfsr = 8'h56;
	int error_cnt = 0;
	int compares = 0;
	int cycles = 0;
	// index order of the tables matches the register outputs below
	logic [7:0] wr_code [12] = '{8'ha4, 8'ha7, 8'ha8, 8'h91, 8'h92, 8'h94, 8'h97, 8'h98, 8'h9b, 8'hab, 8'had, 8'hae};
	logic [7:0] rd_code [12] = '{8'h52, 8'h54, 8'h57, 8'h61, 8'h62, 8'h64, 8'h67, 8'h68, 8'h00, 8'h5b, 8'h5d, 8'h5e};

	// ************************************************************
	// clock, partner and design
	// ************************************************************
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	safety_host_model host (.mclk_in(mclk), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
		.cmd_data_out(cmd_data), .state_a_out(state_a), .config_lock_out(config_lock));

	safety_spi_command_decoder DUT (.mclk_in(mclk), .sys_rst_in(sys_rst), .cmd_valid_in(cmd_valid),
		.cmd_code_in(cmd_code), .cmd_data_in(cmd_data), .state_a_in(state_a), .config_lock_in(config_lock),
		.count_event_in(count_event), .status_flags_in(status_flags), .rd_valid_out(rd_valid),
		.rd_data_out(rd_data), .cmd_ignored_out(ignored), .safety_error_status_two_out(outs[0]),
		.safety_error_status_three_out(outs[1]), .safety_error_status_four_out(outs[2]),
		.pwm_high_time_max_out(outs[3]), .pwm_high_time_min_out(outs[4]), .pwm_low_time_max_out(outs[5]),
		.pwm_low_time_min_out(outs[6]), .power_down_threshold_out(outs[7]),
		.config_crc_reference_out(outs[8]), .analog_selftest_control_out(outs[9]),
		.logic_selftest_control_out(outs[10]), .safety_check_control_out(outs[11]));

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [7:0] lfsr_next(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr_next

	// value a register holds after a write of d to entry i; counters take only the low nibble
	function automatic logic [7:0] after_write(input logic [7:0] old, input logic [7:0] d, input int i,
		input logic acc);
		if (!acc) return old;
		if (i <= `IDX_LAST_COUNTER) return {old[7:4], d[3:0]};
		return d;
	endfunction : after_write

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		compares++;
		if (seen !== want) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// every register at once, so a stray write to a neighbour shows up
	task automatic check_all();
		for (int k = 0; k < 12; k++) begin
			check(outs[k], expv[k]);
		end
	endtask : check_all

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	// hang guard; a full run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			close_out();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		logic [7:0] d;
		logic dg;
		logic lk;
		logic acc;
		sys_rst = 1'b1;
		count_event = 3'h0;
		status_flags = '0;
		repeat (11) @(posedge mclk);
		#1;
		for (int k = 0; k < 12; k++) expv[k] = 8'h00;
		check_all();
		check({7'h00, rd_valid}, 8'h00);
		// release reset and present random hardware flags
		@(posedge mclk);
		sys_rst <= 1'b0;
		lfsr = lfsr_next(lfsr);
		status_flags <= {lfsr[3:0], lfsr[7:4], ~lfsr[3:0]};
		repeat (2) @(posedge mclk);
		#1;
		for (int k = 0; k < 3; k++) expv[k][7:4] = status_flags[k];
		check_all();
		// every write code under each mix of state_a state and lock
		for (int p = 0; p < 5; p++) begin
			dg = (p % 2 == 0);
			lk = (p == 2) || (p == 3);
			for (int i = 0; i < 12; i++) begin
				lfsr = lfsr_next(lfsr);
				d = lfsr;
				acc = (i > 8) || (dg && !lk);
				if (dg && !lk) host.guarded_write(wr_code[i], d);
				else host.issue(wr_code[i], d, dg, lk);
				#1;
				expv[i] = after_write(expv[i], d, i, acc);
				check(outs[i], expv[i]);
				check({7'h00, ignored}, {7'h00, !acc});
				check({7'h00, rd_valid}, 8'h00);
				check_all();
			end
		end
		// reads return the stored value for one cycle
		for (int i = 0; i < 12; i++) begin
			if (i != 8) begin
				host.issue(rd_code[i], 8'h00, 1'b0, 1'b1);
				#1;
				check({7'h00, rd_valid}, 8'h01);
				check(rd_data, expv[i]);
				@(posedge mclk);
				#1;
				check({7'h00, rd_valid}, 8'h00);
			end
		end
		// back to back: the read in the cycle after the write already sees the new value
		lfsr = lfsr_next(lfsr);
		d = lfsr;
		host.write_then_read(wr_code[3], d, rd_code[3]);
		#1;
		expv[3] = d;
		check({7'h00, rd_valid}, 8'h01);
		check(rd_data, d);
		check_all();
		// reserved codes do nothing at all
		host.issue(8'h9d, 8'h5a, 1'b1, 1'b0);
		#1;
		check({6'h00, rd_valid, ignored}, 8'h00);
		host.issue(8'ha1, 8'ha5, 1'b1, 1'b0);
		#1;
		check({6'h00, rd_valid, ignored}, 8'h00);
		check_all();
		// hardware events drive the counters to saturation
		@(posedge mclk);
		count_event <= 3'h7;
		repeat (17) @(posedge mclk);
		count_event <= 3'h0;
		@(posedge mclk);
		#1;
		for (int k = 0; k < 3; k++) expv[k][3:0] = 4'hf;
		check_all();
		// software write of a saturated counter still lands, only the low nibble
		host.guarded_write(8'ha8, 8'hc3);
		#1;
		expv[2][3:0] = 4'h3;
		check_all();
		// an increment in the same cycle as a counter write loses to the write
		@(posedge mclk);
		count_event <= 3'h4;
		host.guarded_write(8'ha8, 8'h5e);
		count_event <= 3'h0;
		#1;
		expv[2][3:0] = 4'he;
		check_all();
		close_out();
	end
endmodule : safety_spi_command_decoder_tb_top
